// file: hdl/srap_regmem.v
`timescale 1ns/1ps
`default_nettype none
module srap_regmem #(
  parameter AW = 6,
  parameter DEPTH = 64
) (
  input wire clock_in,
  input wire rstn_in,
  input wire wr_en_in,
  input wire [AW-1:0] wr_idx_in,
  input wire [7:0] wr_data_in,
  input wire [AW-1:0] rd_idx_in,
  output reg [7:0] rd_data_out
);

  // byte storage, filled by the init walk after reset
  reg [7:0] mem [0:DEPTH-1];

  // write port
  always @(posedge clock_in)
  begin
    if (wr_en_in)
      mem[wr_idx_in] <= wr_data_in;
  end

  // registered read port
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rd_data_out <= 8'h00;
    else
      rd_data_out <= mem[rd_idx_in];
  end

endmodule
`default_nettype wire

// file: hdl/srap_regs.vh
// Functional notes
// - input bits sampled on shift clock rise
// - any slow or paused shift clock works
// - one access is a 24-bit frame
// - first bit one reads, zero writes
// - next fifteen bits are register address
// - write frame stores last eight bits
// - read frame drives register on last eight
// - output driven only during read data bits
// - every field travels most significant bit first
// - wide registers stored low byte first
// - extra eight-clock groups stream more bytes
// - address steps by one per streamed byte
// - bits five and two choose address direction
// - freeze bit holds address while streaming
`ifndef SRAP_REGS_VH
`define SRAP_REGS_VH

// ============================================================
// frame layout and field positions
`define SRAP_HEAD_LAST 4'hF
`define SRAP_BYTE_LAST 3'h7
`define SRAP_ASC_HI_BIT 5
`define SRAP_ASC_LO_BIT 2
`define SRAP_FREEZE_BIT 0
`define SRAP_NSLOT 6'h26

// ============================================================
// register offsets (byte addresses)
`define SRAP_OFS_SPI_IF 15'h0000
`define SRAP_OFS_DEV_OP 15'h0002
`define SRAP_OFS_CATEGORY 15'h0003
`define SRAP_OFS_PART_ID 15'h0004
`define SRAP_OFS_MAKER_ID 15'h000C
`define SRAP_OFS_USER 15'h0010
`define SRAP_OFS_CLK0 15'h0029
`define SRAP_OFS_CLK1 15'h002A
`define SRAP_OFS_CLK2 15'h002B
`define SRAP_OFS_SYNC_POS 15'h002C
`define SRAP_OFS_FS_A 15'h0030
`define SRAP_OFS_FS_B 15'h0032
`define SRAP_OFS_REF_BYP 15'h0038
`define SRAP_OFS_TSTAMP 15'h003B
`define SRAP_OFS_PREEMPH 15'h0048
`define SRAP_OFS_IN_SEL 15'h0060
`define SRAP_OFS_CAL_ON 15'h0061
`define SRAP_OFS_CAL_SET0 15'h0062
`define SRAP_OFS_CAL_SET2 15'h0064
`define SRAP_OFS_CAL_MEAN 15'h0068
`define SRAP_OFS_CAL_STATE 15'h006A
`define SRAP_OFS_CAL_PIN 15'h006B
`define SRAP_OFS_CAL_TRIG 15'h006C
`define SRAP_OFS_CAL_LOWP 15'h006E
`define SRAP_OFS_CAL_RB_EN 15'h0070
`define SRAP_OFS_CAL_RB 15'h0071
`define SRAP_OFS_GAIN_A 15'h007A
`define SRAP_OFS_GAIN_B 15'h007B
`define SRAP_OFS_REF_TRIM 15'h007C
`define SRAP_OFS_TERM_A 15'h007E
`define SRAP_OFS_TERM_B 15'h007F
`define SRAP_OFS_DITHER 15'h009D
`define SRAP_OFS_LOW_BIT 15'h0160
`define SRAP_OFS_LINK_EN 15'h0200
`define SRAP_OFS_LINK_MODE 15'h0201
`define SRAP_OFS_MF_LEN 15'h0202
`define SRAP_OFS_SYNC_REQ 15'h0203
`define SRAP_OFS_LINK_CTL 15'h0204
`define SRAP_OFS_LINK_TEST 15'h0205
`define SRAP_OFS_LINK_DID 15'h0206
`define SRAP_OFS_FRAME_CHR 15'h0207

// ============================================================
// reset values
`define SRAP_RST_ZERO 8'h00
`define SRAP_RST_TRIM 8'h00
`define SRAP_RST_SPI_IF 8'h30
`define SRAP_RST_CLK2 8'h11
`define SRAP_RST_FS_LO 8'h00
`define SRAP_RST_FS_HI 8'hA0
`define SRAP_RST_IN_SEL 8'h01
`define SRAP_RST_CAL_ON 8'h01
`define SRAP_RST_CAL_SET0 8'h01
`define SRAP_RST_CAL_SET2 8'h02
`define SRAP_RST_CAL_MEAN 8'h61
`define SRAP_RST_CAL_TRIG 8'h01
`define SRAP_RST_CAL_LOWP 8'h88
`define SRAP_RST_LINK_EN 8'h01
`define SRAP_RST_LINK_MODE 8'h02
`define SRAP_RST_MF_LEN 8'h1F
`define SRAP_RST_SYNC_REQ 8'h01
`define SRAP_RST_LINK_CTL 8'h03

`endif

// file: hdl/srap_sync.v
`timescale 1ns/1ps
`default_nettype none
module srap_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] RESET_VAL = 3'h2
) (
  input wire clock_in,
  input wire rstn_in,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  // first stage, read only by the second stage
  reg [WIDTH-1:0] meta_reg;

  // two flip-flops per pin
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// file: hdl/srap_top.v
`timescale 1ns/1ps
`default_nettype none
`include "srap_regs.vh"
module srap_top #(
  // identity values below are arbitrary
  parameter [7:0] CATEGORY_CODE = 8'h5A,
  parameter [7:0] PART_CODE = 8'hA5,
  parameter [15:0] MAKER_CODE = 16'h1234,
  parameter SLOT_DEPTH = 64
) (
  input wire clock_in,
  input wire rstn_in,
  input wire serial_clock_in,
  input wire serial_select_low_in,
  input wire serial_in_line_in,
  output reg serial_out_line_out,
  output reg serial_out_line_oe_out,
  input wire [7:0] sync_capture_pos_in,
  input wire [7:0] calibration_state_in,
  output wire init_busy_out,
  output reg reg_wr_pulse_out,
  output reg [14:0] reg_wr_addr_out,
  output reg [7:0] reg_wr_data_out
);

  // ============================================================
  // states
  localparam [1:0] ST_INIT = 2'h0;
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_HEAD = 2'h2;
  localparam [1:0] ST_DATA = 2'h3;

  // ============================================================
  // functions

  // maps an address to {hit, slot index}
  function [6:0] slot_of;
    input [14:0] a;
    begin
      if (a == `SRAP_OFS_SPI_IF) slot_of = 7'h40;
      else if (a == `SRAP_OFS_DEV_OP) slot_of = 7'h41;
      else if (a == `SRAP_OFS_USER) slot_of = 7'h42;
      else if (a == `SRAP_OFS_CLK0) slot_of = 7'h43;
      else if (a == `SRAP_OFS_CLK1) slot_of = 7'h44;
      else if (a == `SRAP_OFS_CLK2) slot_of = 7'h45;
      // 16-bit ranges, low byte at the lower address
      else if (a == `SRAP_OFS_FS_A) slot_of = 7'h46;
      else if (a == `SRAP_OFS_FS_A + 15'h0001) slot_of = 7'h47;
      else if (a == `SRAP_OFS_FS_B) slot_of = 7'h48;
      else if (a == `SRAP_OFS_FS_B + 15'h0001) slot_of = 7'h49;
      else if (a == `SRAP_OFS_REF_BYP) slot_of = 7'h4A;
      else if (a == `SRAP_OFS_TSTAMP) slot_of = 7'h4B;
      else if (a == `SRAP_OFS_PREEMPH) slot_of = 7'h4C;
      else if (a == `SRAP_OFS_IN_SEL) slot_of = 7'h4D;
      else if (a == `SRAP_OFS_CAL_ON) slot_of = 7'h4E;
      else if (a == `SRAP_OFS_CAL_SET0) slot_of = 7'h4F;
      else if (a == `SRAP_OFS_CAL_SET2) slot_of = 7'h50;
      else if (a == `SRAP_OFS_CAL_MEAN) slot_of = 7'h51;
      else if (a == `SRAP_OFS_CAL_PIN) slot_of = 7'h52;
      else if (a == `SRAP_OFS_CAL_TRIG) slot_of = 7'h53;
      else if (a == `SRAP_OFS_CAL_LOWP) slot_of = 7'h54;
      else if (a == `SRAP_OFS_CAL_RB_EN) slot_of = 7'h55;
      else if (a == `SRAP_OFS_CAL_RB) slot_of = 7'h56;
      else if (a == `SRAP_OFS_GAIN_A) slot_of = 7'h57;
      else if (a == `SRAP_OFS_GAIN_B) slot_of = 7'h58;
      else if (a == `SRAP_OFS_REF_TRIM) slot_of = 7'h59;
      else if (a == `SRAP_OFS_TERM_A) slot_of = 7'h5A;
      else if (a == `SRAP_OFS_TERM_B) slot_of = 7'h5B;
      else if (a == `SRAP_OFS_DITHER) slot_of = 7'h5C;
      else if (a == `SRAP_OFS_LOW_BIT) slot_of = 7'h5D;
      else if (a == `SRAP_OFS_LINK_EN) slot_of = 7'h5E;
      else if (a == `SRAP_OFS_LINK_MODE) slot_of = 7'h5F;
      else if (a == `SRAP_OFS_MF_LEN) slot_of = 7'h60;
      else if (a == `SRAP_OFS_SYNC_REQ) slot_of = 7'h61;
      else if (a == `SRAP_OFS_LINK_CTL) slot_of = 7'h62;
      else if (a == `SRAP_OFS_LINK_TEST) slot_of = 7'h63;
      else if (a == `SRAP_OFS_LINK_DID) slot_of = 7'h64;
      else if (a == `SRAP_OFS_FRAME_CHR) slot_of = 7'h65;
      // unmapped or read-only: no storage
      else slot_of = 7'h00;
    end
  endfunction

  // reset value of each storage slot
  function [7:0] rst_of;
    input [5:0] idx;
    begin
      case (idx)
        6'h00: rst_of = `SRAP_RST_SPI_IF;
        6'h05: rst_of = `SRAP_RST_CLK2;
        6'h06: rst_of = `SRAP_RST_FS_LO;
        6'h07: rst_of = `SRAP_RST_FS_HI;
        6'h08: rst_of = `SRAP_RST_FS_LO;
        6'h09: rst_of = `SRAP_RST_FS_HI;
        6'h0D: rst_of = `SRAP_RST_IN_SEL;
        6'h0E: rst_of = `SRAP_RST_CAL_ON;
        6'h0F: rst_of = `SRAP_RST_CAL_SET0;
        6'h10: rst_of = `SRAP_RST_CAL_SET2;
        6'h11: rst_of = `SRAP_RST_CAL_MEAN;
        6'h13: rst_of = `SRAP_RST_CAL_TRIG;
        6'h14: rst_of = `SRAP_RST_CAL_LOWP;
        // trim slots start from a fixed value
        6'h17, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C: rst_of = `SRAP_RST_TRIM;
        6'h1E: rst_of = `SRAP_RST_LINK_EN;
        6'h1F: rst_of = `SRAP_RST_LINK_MODE;
        6'h20: rst_of = `SRAP_RST_MF_LEN;
        6'h21: rst_of = `SRAP_RST_SYNC_REQ;
        6'h22: rst_of = `SRAP_RST_LINK_CTL;
        default: rst_of = `SRAP_RST_ZERO;
      endcase
    end
  endfunction

  // next streaming address
  function [14:0] step_addr;
    input [14:0] a;
    input [7:0] cfg;
    input [7:0] usr;
    begin
      // freeze bit keeps the address
      if (usr[`SRAP_FREEZE_BIT])
        step_addr = a;
      // either direction bit set means ascending
      else if (cfg[`SRAP_ASC_HI_BIT] | cfg[`SRAP_ASC_LO_BIT])
        step_addr = a + 15'h0001;
      else
        step_addr = a - 15'h0001;
    end
  endfunction

  // ============================================================
  // pin synchronisers
  wire [2:0] pins_sync;
  wire sclk_s;
  wire sel_low_s;
  wire sdi_s;

  // select idles high, so it resets to one
  srap_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h2)
  ) u_sync (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .async_in({serial_clock_in, serial_select_low_in, serial_in_line_in}),
    .sync_out(pins_sync)
  );

  assign sclk_s = pins_sync[2];
  assign sel_low_s = pins_sync[1];
  assign sdi_s = pins_sync[0];

  // ============================================================
  // state registers
  reg [1:0] state_reg; // frame state
  reg sclk_d_reg; // previous synced shift clock
  reg [5:0] init_idx_reg; // init walk slot
  reg [3:0] head_cnt_reg; // header bits taken
  reg [2:0] bit_idx_reg; // data bit within byte
  reg [15:0] shift_reg; // incoming bits
  reg rd_mode_reg; // frame is a read
  reg [14:0] cur_addr_reg; // current register address
  reg [7:0] cfg_reg; // shadow of interface config
  reg [7:0] usr_reg; // shadow of user serial config
  reg fetch_reg; // read requested this cycle
  reg load_reg; // read data valid this cycle
  reg [7:0] out_byte_reg; // byte being shifted out
  reg [7:0] rd_byte_next; // read data mux

  // shift clock edges; only the second sync stage is seen
  wire sclk_rise;
  wire sclk_fall;
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;

  // ============================================================
  // decode and storage
  wire [6:0] cur_slot;
  wire [7:0] in_byte;
  wire in_frame;
  wire byte_done;
  wire wr_fire;
  wire mem_we;
  wire [5:0] mem_widx;
  wire [7:0] mem_wdata;
  wire [7:0] mem_rdata;

  assign cur_slot = slot_of(cur_addr_reg);
  // completed byte, most significant bit first
  assign in_byte = {shift_reg[6:0], sdi_s};
  assign in_frame = (state_reg == ST_HEAD) || (state_reg == ST_DATA);
  // a byte only completes on its eighth rise, so partial ones drop
  assign byte_done = sclk_rise && !sel_low_s && (state_reg == ST_DATA) &&
                     (bit_idx_reg == `SRAP_BYTE_LAST);
  // read bytes are ignored, writes store the last eight bits
  assign wr_fire = byte_done && !rd_mode_reg;
  assign init_busy_out = (state_reg == ST_INIT);

  // init walk owns the write port, then the link does
  assign mem_we = init_busy_out || (wr_fire && cur_slot[6]);
  assign mem_widx = init_busy_out ? init_idx_reg : cur_slot[5:0];
  assign mem_wdata = init_busy_out ? rst_of(init_idx_reg) : in_byte;

  // register storage
  srap_regmem #(
    .AW(6),
    .DEPTH(SLOT_DEPTH)
  ) u_mem (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .wr_en_in(mem_we),
    .wr_idx_in(mem_widx),
    .wr_data_in(mem_wdata),
    .rd_idx_in(cur_slot[5:0]),
    .rd_data_out(mem_rdata)
  );

  // read data: fixed codes, live inputs, storage or zero
  always @*
  begin
    if (cur_addr_reg == `SRAP_OFS_CATEGORY)
      rd_byte_next = CATEGORY_CODE;
    else if (cur_addr_reg == `SRAP_OFS_PART_ID)
      rd_byte_next = PART_CODE;
    else if (cur_addr_reg == `SRAP_OFS_MAKER_ID)
      rd_byte_next = MAKER_CODE[7:0];
    else if (cur_addr_reg == `SRAP_OFS_MAKER_ID + 15'h0001)
      rd_byte_next = MAKER_CODE[15:8];
    else if (cur_addr_reg == `SRAP_OFS_SYNC_POS)
      rd_byte_next = sync_capture_pos_in;
    else if (cur_addr_reg == `SRAP_OFS_CAL_STATE)
      rd_byte_next = calibration_state_in;
    else if (cur_slot[6])
      rd_byte_next = mem_rdata;
    else
      rd_byte_next = 8'h00;
  end

  // ============================================================
  // frame engine; header and data bits move only on shift clock rises
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= ST_INIT;
      sclk_d_reg <= 1'b0;
      init_idx_reg <= 6'h00;
      head_cnt_reg <= 4'h0;
      bit_idx_reg <= 3'h0;
      shift_reg <= 16'h0000;
      rd_mode_reg <= 1'b0;
      cur_addr_reg <= 15'h0000;
      fetch_reg <= 1'b0;
      load_reg <= 1'b0;
    end
    else
    begin
      sclk_d_reg <= sclk_s;
      // fetch then load: storage read takes one cycle
      load_reg <= fetch_reg;
      fetch_reg <= 1'b0;
      case (state_reg)
        // walk the 38 used slots (SRAP_NSLOT) to their reset values
        ST_INIT:
        begin
          init_idx_reg <= init_idx_reg + 6'h01;
          if (init_idx_reg == `SRAP_NSLOT - 6'h01)
            state_reg <= ST_IDLE;
        end
        // link ignored until select goes low
        ST_IDLE:
        begin
          head_cnt_reg <= 4'h0;
          bit_idx_reg <= 3'h0;
          if (!sel_low_s)
            state_reg <= ST_HEAD;
        end
        // direction bit and address
        ST_HEAD:
        begin
          if (sel_low_s)
            state_reg <= ST_IDLE;
          else if (sclk_rise)
          begin
            shift_reg <= {shift_reg[14:0], sdi_s};
            head_cnt_reg <= head_cnt_reg + 4'h1;
            if (head_cnt_reg == `SRAP_HEAD_LAST)
            begin
              rd_mode_reg <= shift_reg[14];
              cur_addr_reg <= {shift_reg[13:0], sdi_s};
              fetch_reg <= shift_reg[14];
              bit_idx_reg <= 3'h0;
              state_reg <= ST_DATA;
            end
          end
        end
        // data bytes, streaming while select stays low
        ST_DATA:
        begin
          if (sel_low_s)
            state_reg <= ST_IDLE;
          else if (sclk_rise)
          begin
            shift_reg <= {shift_reg[14:0], sdi_s};
            bit_idx_reg <= bit_idx_reg + 3'h1;
            if (bit_idx_reg == `SRAP_BYTE_LAST)
            begin
              cur_addr_reg <= step_addr(cur_addr_reg, cfg_reg, usr_reg);
              fetch_reg <= rd_mode_reg;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ============================================================
  // shadows of the two registers that steer streaming
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cfg_reg <= `SRAP_RST_SPI_IF;
      usr_reg <= `SRAP_RST_ZERO;
    end
    else if (wr_fire && cur_addr_reg == `SRAP_OFS_SPI_IF)
      cfg_reg <= in_byte;
    else if (wr_fire && cur_addr_reg == `SRAP_OFS_USER)
      usr_reg <= in_byte;
  end

  // ============================================================
  // serial output: driven on falls during read data only
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      out_byte_reg <= 8'h00;
      serial_out_line_out <= 1'b0;
      serial_out_line_oe_out <= 1'b0;
    end
    else
    begin
      if (load_reg)
        out_byte_reg <= rd_byte_next;
      // release at once when the frame ends
      if (!in_frame || sel_low_s)
        serial_out_line_oe_out <= 1'b0;
      else if (sclk_fall && state_reg == ST_DATA && rd_mode_reg)
      begin
        serial_out_line_out <= out_byte_reg[3'h7 - bit_idx_reg];
        serial_out_line_oe_out <= 1'b1;
      end
    end
  end

  // ============================================================
  // write notice to the rest of the device
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      reg_wr_pulse_out <= 1'b0;
      reg_wr_addr_out <= 15'h0000;
      reg_wr_data_out <= 8'h00;
    end
    else
    begin
      reg_wr_pulse_out <= wr_fire && cur_slot[6];
      if (wr_fire && cur_slot[6])
      begin
        reg_wr_addr_out <= cur_addr_reg;
        reg_wr_data_out <= in_byte;
      end
    end
  end

endmodule
`default_nettype wire

// file: verification/srap_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// host master of the serial register link
module srap_host_model (
  input wire logic clock_in,
  input wire logic serial_out_line_in,
  output var logic serial_clock_out,
  output var logic serial_select_low_out,
  output var logic serial_in_line_out
);
  // link idle: clock low, deselected
  initial
  begin
    serial_clock_out = 1'b0;
    serial_select_low_out = 1'b1;
    serial_in_line_out = 1'b0;
  end
  // one frame: header then nb bytes, byte 0 in bits 7:0; cut stops early, pause stalls bit 20
  task automatic xfer(input logic rd, input logic [14:0] addr, input int nb,
    input logic [63:0] wd, input int cut, input int pause, output logic [63:0] rdat);
    logic [15:0] hdr;
    logic b;
    int j;
    hdr = {rd, addr};
    rdat = 64'h0;
    b = 1'b0;
    @(posedge clock_in);
    serial_select_low_out <= 1'b0;
    repeat (4) @(posedge clock_in);
    for (int i = 0; i < 16 + 8 * nb; i++)
    begin
      if (cut != 0 && i == cut)
        break;
      j = i - 16;
      b = (i < 16) ? hdr[15 - i] : wd[8 * (j / 8) + 7 - j % 8];
      serial_clock_out <= 1'b0;
      serial_in_line_out <= b; // data moves while clock is low
      repeat (4) @(posedge clock_in);
      serial_clock_out <= 1'b1;
      if (i >= 16)
        rdat[8 * (j / 8) + 7 - j % 8] = serial_out_line_in;
      repeat ((i == 20) ? pause + 4 : 4) @(posedge clock_in);
    end
    serial_clock_out <= 1'b0;
    serial_in_line_out <= ~b; // no stale level left on the line
    repeat (4) @(posedge clock_in);
    serial_select_low_out <= 1'b1;
    repeat (6) @(posedge clock_in);
  endtask
endmodule
`default_nettype wire

// file: verification/srap_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// checker on the serial register port
module srap_top_chk (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic serial_clock_in,
  input wire logic serial_select_low_in,
  input wire logic serial_out_line_out,
  input wire logic serial_out_line_oe_out,
  input wire logic init_busy_out,
  input wire logic reg_wr_pulse_out,
  input wire logic [14:0] reg_wr_addr_out,
  input wire logic [7:0] reg_wr_data_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);
  logic [7:0] busy_cnt; // clocks spent in the reset-value walk
  // count walk cycles so that its length can be judged
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      busy_cnt <= 8'h00;
    else if (init_busy_out && busy_cnt != 8'hFF)
      busy_cnt <= busy_cnt + 8'h01;
  end
  // select seen high long enough to pass the sync stages
  sequence s_sel_idle;
    serial_select_low_in [*5];
  endsequence
  // a write strobe lasting exactly one clock
  sequence s_one_pulse;
    reg_wr_pulse_out ##1 !reg_wr_pulse_out;
  endsequence
  a_idle_no_drive: assert property (s_sel_idle |-> !serial_out_line_oe_out)
    else $error("data out driven while deselected");
  a_drive_on_low: assert property ($rose(serial_out_line_oe_out) |-> !serial_clock_in)
    else $error("data out enabled outside a low clock phase");
  a_bit_holds_high: assert property (serial_out_line_oe_out
    && $past(serial_out_line_oe_out) && serial_clock_in && $past(serial_clock_in)
    |-> $stable(serial_out_line_out))
    else $error("data out bit moved while clock high");
  a_drive_ends_sel: assert property ($fell(serial_out_line_oe_out)
    |-> serial_select_low_in && $past(serial_select_low_in))
    else $error("data out released while still selected");
  a_pulse_single: assert property (reg_wr_pulse_out |-> s_one_pulse)
    else $error("write strobe longer than one clock");
  a_pulse_after_rise: assert property (reg_wr_pulse_out
    |-> serial_clock_in && $past(serial_clock_in))
    else $error("write strobe not tied to a clock rise");
  a_pulse_in_frame: assert property (reg_wr_pulse_out |-> !serial_select_low_in)
    else $error("write strobe without a selected frame");
  a_pulse_no_drive: assert property (reg_wr_pulse_out |-> !serial_out_line_oe_out)
    else $error("write strobe during a driven read");
  a_wr_info_holds: assert property (!reg_wr_pulse_out
    |-> $stable(reg_wr_addr_out) && $stable(reg_wr_data_out))
    else $error("write address or data moved without strobe");
  a_walk_length: assert property ($fell(init_busy_out) |-> busy_cnt >= 37 && busy_cnt <= 39)
    else $error("reset-value walk has wrong length");
  a_walk_quiet: assert property (init_busy_out
    |-> !serial_out_line_oe_out && !reg_wr_pulse_out)
    else $error("link active during reset-value walk");
endmodule
bind srap_top srap_top_chk chk (.clock_in(clock_in), .rstn_in(rstn_in),
  .serial_clock_in(serial_clock_in), .serial_select_low_in(serial_select_low_in),
  .serial_out_line_out(serial_out_line_out), .serial_out_line_oe_out(serial_out_line_oe_out),
  .init_busy_out(init_busy_out), .reg_wr_pulse_out(reg_wr_pulse_out),
  .reg_wr_addr_out(reg_wr_addr_out), .reg_wr_data_out(reg_wr_data_out));
`default_nettype wire

// file: verification/test_serial_register_access_port.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench for the serial register port
module test_serial_register_access_port;
  localparam logic [7:0] CAT = 8'h6C; // arbitrary
  localparam logic [7:0] PART = 8'h9E; // arbitrary
  localparam logic [15:0] MAKER = 16'h2B7D; // arbitrary
  localparam logic [7:0] SPOS = 8'h3C; // capture position input value
  localparam logic [7:0] CST = 8'hC3; // calibration state input value
  logic clock_in, rstn_in, sclk, sel_n, serial_in_line, serial_out_line, oe, sdo_last, sdo_wire, busy, wp;
  logic [14:0] wa;
  logic [7:0] wd, spos, cst;
  logic [22:0] wq [$]; // observed writes, address and data
  int error_cnt = 0;
  int comparisons = 0;
  logic [22:0] tbl [16] = '{{15'h000C, MAKER[7:0]}, {15'h000D, MAKER[15:8]}, {15'h0010, 8'h00},
    {15'h002B, 8'h11}, {15'h0030, 8'h00}, {15'h0031, 8'hA0}, {15'h0033, 8'hA0},
    {15'h0060, 8'h01}, {15'h0068, 8'h61}, {15'h006E, 8'h88}, {15'h0202, 8'h1F},
    {15'h0204, 8'h03}, {15'h002C, SPOS}, {15'h006A, CST}, {15'h0005, 8'h00}, {15'h7FFF, 8'h00}};
  // clock at 25 MHz
  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  // data out wire: undriven shows the inverse of its last value
  initial sdo_last = 1'b0;
  always @(posedge clock_in)
    if (oe === 1'b1)
      sdo_last <= serial_out_line;
  assign sdo_wire = (oe === 1'b1) ? serial_out_line : ~sdo_last;
  // record every write strobe
  always @(posedge clock_in)
    if (wp === 1'b1)
      wq.push_back({wa, wd});
  srap_host_model host (.clock_in(clock_in), .serial_out_line_in(sdo_wire),
    .serial_clock_out(sclk), .serial_select_low_out(sel_n), .serial_in_line_out(serial_in_line));
  srap_top #(.CATEGORY_CODE(CAT), .PART_CODE(PART), .MAKER_CODE(MAKER)) uut (
    .clock_in(clock_in), .rstn_in(rstn_in), .serial_clock_in(sclk),
    .serial_select_low_in(sel_n), .serial_in_line_in(serial_in_line), .serial_out_line_out(serial_out_line),
    .serial_out_line_oe_out(oe), .sync_capture_pos_in(spos), .calibration_state_in(cst),
    .init_busy_out(busy), .reg_wr_pulse_out(wp), .reg_wr_addr_out(wa), .reg_wr_data_out(wd));
  task automatic complete_run();
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [14:0] a, input int n, input logic [63:0] d, input int cut = 0,
    input int pause = 0);
    logic [63:0] r;
    host.xfer(1'b0, a, n, d, cut, pause, r);
  endtask
  task automatic rd(input logic [14:0] a, input int n, output logic [63:0] r);
    host.xfer(1'b1, a, n, 64'h0, 0, 0, r);
  endtask
  task automatic chk_byte(input logic [14:0] a, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected read of %h expected %h seen %h", a, e, g);
    end
  endtask
  task automatic rd1(input logic [14:0] a, input logic [7:0] e);
    logic [63:0] r;
    rd(a, 1, r);
    chk_byte(a, e, r[7:0]);
  endtask
  task automatic chk_wr(input logic [14:0] a, input logic [7:0] e);
    logic [22:0] w;
    comparisons++;
    w = (wq.size() > 0) ? wq.pop_front() : 23'h7FFFFF;
    if (w !== {a, e})
    begin
      error_cnt++;
      $display("unexpected write expected %h seen %h", {a, e}, w);
    end
  endtask
  task automatic chk_none();
    comparisons++;
    if (wq.size() != 0)
    begin
      error_cnt++;
      $display("unexpected write count expected 0 seen %0d", wq.size());
      wq.delete();
    end
  endtask
  // main sequence
  initial
  begin
    logic [63:0] r;
    int k;
    rstn_in = 1'b0;
    spos = SPOS;
    cst = CST; // calibration state input, only read back through 006A
    repeat (8) @(posedge clock_in);
    rstn_in <= 1'b1;
    for (k = 0; k < 100 && busy !== 1'b0; k++)
      @(posedge clock_in);
    if (k == 100)
    begin
      error_cnt++;
      $display("unexpected init_busy_out expected 0 seen 1");
      complete_run();
    end
    repeat (3) @(posedge clock_in);
    rd(15'h0000, 5, r);
    chk_byte(15'h0000, 8'h30, r[7:0]);
    chk_byte(15'h0001, 8'h00, r[15:8]);
    chk_byte(15'h0002, 8'h00, r[23:16]);
    chk_byte(15'h0003, CAT, r[31:24]);
    chk_byte(15'h0004, PART, r[39:32]);
    for (k = 0; k < 16; k++)
      rd1(tbl[k][22:8], tbl[k][7:0]);
    wr(15'h0029, 1, 64'h5C, 0, 200);
    chk_wr(15'h0029, 8'h5C);
    rd1(15'h0029, 8'h5C);
    wr(15'h0003, 1, 64'h77); // read-only place refuses
    wr(15'h0004, 1, 64'h77); // only listed places are ever written
    wr(15'h0061, 1, 64'h00, 20);
    chk_none();
    rd1(15'h0003, CAT);
    rd1(15'h0061, 8'h01);
    wr(15'h0200, 3, 64'hC3B2A1);
    chk_wr(15'h0200, 8'hA1);
    chk_wr(15'h0201, 8'hB2);
    chk_wr(15'h0202, 8'hC3);
    wr(15'h0000, 1, 64'h00); // both direction bits clear
    chk_wr(15'h0000, 8'h00);
    wr(15'h002B, 3, 64'h332211);
    chk_wr(15'h002B, 8'h11);
    chk_wr(15'h002A, 8'h22);
    chk_wr(15'h0029, 8'h33);
    rd(15'h002B, 2, r);
    chk_byte(15'h002B, 8'h11, r[7:0]);
    chk_byte(15'h002A, 8'h22, r[15:8]);
    wr(15'h0000, 1, 64'h04); // low direction bit alone
    chk_wr(15'h0000, 8'h04);
    wr(15'h0206, 2, 64'h6655);
    chk_wr(15'h0206, 8'h55);
    chk_wr(15'h0207, 8'h66);
    wr(15'h0010, 1, 64'h01); // address freeze on
    chk_wr(15'h0010, 8'h01);
    wr(15'h0038, 2, 64'h2211);
    chk_wr(15'h0038, 8'h11);
    chk_wr(15'h0038, 8'h22);
    rd(15'h0038, 2, r);
    chk_byte(15'h0038, 8'h22, r[7:0]);
    chk_byte(15'h0038, 8'h22, r[15:8]);
    chk_none();
    complete_run();
  end
endmodule
`default_nettype wire
